/* File: rtl/padc_core.sv */
`timescale 1ns/1ps
`include "padc_defs.svh"
// How it works
// - a sample is taken on every rising clock edge while the converter is awake; nothing happens on falling edges.
// - the result for a sample appears on the data pins six clock cycles after its sampling edge if the converter stays awake and capture ready stays high.
// - with output enable low the twelve data pins are driven, with it high they all float.
// - sleep request high puts the converter in low-power mode, low keeps it converting.
// - each result is 12-bit offset binary, bit 0 the least and bit 11 the most significant.
// - inputs below full scale give code 0 and above full scale saturate at 4095, never wrapping.
module padc_core
#(
	parameter int LATENCY = `PADC_LATENCY,
	parameter int W = `PADC_WORD_W
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic signed [`PADC_SAMPLE_W-1:0] i_sample,
	input wire logic i_out_en_n,
	input wire logic i_sleep_request,
	input wire logic i_capture_ready,
	output logic [W-1:0] o_conversion_word,
	output logic [W-1:0] o_conversion_word_oe_n,
	output logic o_word_valid,
	output logic o_sleeping,
	output logic o_stall
);
	import padc_pkg::*;
	// sampling stage plus LATENCY-2 stages; buffer slot and output register make up the rest
	padc_beat_type pipe_q [LATENCY-1];
	padc_state_type state_q;
	padc_state_type state_d;
	logic [3:0] fill_q;
	logic [W-1:0] word_q;
	logic [W-1:0] oe_n_q;
	logic valid_q;
	logic sleeping_q;
	logic stall_q;
	logic [W-1:0] code_clamped;
	logic [W-1:0] code_offset;
	wire active = (state_q != PADC_ST_SLEEP);
	wire buf_ready;
	wire buf_valid;
	wire [W-1:0] buf_data;
	wire buf_pop;
	// signed sample clamp, then offset-binary conversion
	assign code_clamped = (i_sample > 13'sd2047) ? 12'h7FF :
		(i_sample < -13'sd2048) ? 12'h800 : i_sample[W-1:0];
	assign code_offset = {~code_clamped[W-1], code_clamped[W-2:0]};
	assign buf_pop = buf_valid && i_capture_ready;
	// sampling stage: rising edge only, and only when awake
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			pipe_q[0] <= '0;
		else
			pipe_q[0] <= '{valid: active, word: code_offset};
	end
	genvar g;
	generate
		for (g = 1; g < LATENCY - 1; g++)
		begin : g_pipe
			always_ff @(posedge i_sys_clk)
			begin
				if (!i_rst_n)
					pipe_q[g] <= '0;
				else
					pipe_q[g] <= '{valid: pipe_q[g-1].valid && active, word: pipe_q[g-1].word};
			end
			property p_stage;
				@(posedge i_sys_clk) disable iff (!i_rst_n)
				1'b1 |=> (pipe_q[g].word == $past(pipe_q[g-1].word))
					&& (!pipe_q[g].valid || $past(pipe_q[g-1].valid));
			endproperty
			a_stage: assert property (p_stage) else $error("pipeline stage skipped or repeated");
		end
	endgenerate
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			PADC_ST_SLEEP: if (!i_sleep_request) state_d = PADC_ST_FILL;
			PADC_ST_FILL: if (i_sleep_request) state_d = PADC_ST_SLEEP;
				else if (fill_q == 4'(LATENCY - 1)) state_d = PADC_ST_RUN;
			PADC_ST_RUN: if (i_sleep_request) state_d = PADC_ST_SLEEP;
			default: state_d = PADC_ST_SLEEP;
		endcase
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			state_q <= PADC_ST_SLEEP;
			fill_q <= 4'd0;
		end
		else
		begin
			state_q <= state_d;
			fill_q <= (state_q == PADC_ST_FILL) ? fill_q + 4'd1 : 4'd0;
		end
	end
	padc_skid #(
		.WIDTH(W)
	) u_buf (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_valid(pipe_q[LATENCY-2].valid),
		.i_data(pipe_q[LATENCY-2].word),
		.o_ready(buf_ready),
		.o_valid(buf_valid),
		.o_data(buf_data),
		.i_ready(i_capture_ready)
	);
	// output register: word holds when no new word is popped
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			word_q <= `PADC_CODE_MIN;
			oe_n_q <= `PADC_OE_FLOAT;
			valid_q <= 1'b0;
			sleeping_q <= 1'b1;
			stall_q <= 1'b0;
		end
		else
		begin
			if (buf_pop)
				word_q <= buf_data;
			valid_q <= buf_pop;
			oe_n_q <= i_out_en_n ? `PADC_OE_FLOAT : `PADC_OE_DRIVE;
			sleeping_q <= i_sleep_request;
			stall_q <= !buf_ready;
		end
	end
	assign o_conversion_word = word_q;
	assign o_conversion_word_oe_n = oe_n_q;
	assign o_word_valid = valid_q;
	assign o_sleeping = sleeping_q;
	assign o_stall = stall_q;
	property p_latency;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(!i_sleep_request && active && buf_ready && !buf_valid && i_capture_ready) [*1] ##0
		(!i_sleep_request && active && i_capture_ready) [*7]
		|-> ##0 $past(code_offset, 7) == word_q || !valid_q;
	endproperty
	a_latency: assert property (p_latency) else $error("word not six cycles after sample");
	property p_oe;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		##1 (oe_n_q == ($past(i_out_en_n) ? 12'hFFF : 12'h000));
	endproperty
	a_oe: assert property (p_oe) else $error("output enable mismatch");
	property p_sleep;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_sleep_request |=> (state_q == PADC_ST_SLEEP) ##1 !pipe_q[0].valid;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	property p_sat_hi;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_sample > 13'sd2047 && active) |=> pipe_q[0].word == 12'hFFF;
	endproperty
	a_sat_hi: assert property (p_sat_hi) else $error("over range not 4095");
	property p_sat_lo;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_sample < -13'sd2048) |=> pipe_q[0].word == 12'h000;
	endproperty
	a_sat_lo: assert property (p_sat_lo) else $error("under range not 0");
	property p_fmt;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_sample == 13'sd0) |=> pipe_q[0].word == 12'h800;
	endproperty
	a_fmt: assert property (p_fmt) else $error("midscale not offset binary");
	property p_rise;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(active && !i_sleep_request) |=> pipe_q[0].valid;
	endproperty
	a_rise: assert property (p_rise) else $error("sample missed on rising edge");
	property p_hold;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!buf_pop |=> $stable(word_q);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed without pop");
	// every pop shows one edge later as a one-cycle strobe carrying that word
	property p_valid_pulse;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		buf_pop |=> valid_q && (word_q == $past(buf_data));
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("popped word not presented");
	property p_valid_idle;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!buf_pop |=> !valid_q;
	endproperty
	a_valid_idle: assert property (p_valid_idle) else $error("strobe without a popped word");
	property p_oe_drive;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_out_en_n |=> oe_n_q == `PADC_OE_DRIVE;
	endproperty
	a_oe_drive: assert property (p_oe_drive) else $error("data pins not driven");
	property p_sleep_flag;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> sleeping_q == $past(i_sleep_request);
	endproperty
	a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag does not follow request");
	// wake goes through the refill state before steady running
	property p_wake;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == PADC_ST_SLEEP && !i_sleep_request) |=> state_q == PADC_ST_FILL;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake after sleep released");
	property p_refill;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == PADC_ST_FILL && !i_sleep_request && fill_q == 4'(LATENCY - 1)) |=> state_q == PADC_ST_RUN;
	endproperty
	a_refill: assert property (p_refill) else $error("refill did not end");
	property p_dormant;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == PADC_ST_SLEEP) |=> !pipe_q[0].valid;
	endproperty
	a_dormant: assert property (p_dormant) else $error("sample taken while asleep");
	// in-range samples map to offset binary by adding half scale
	property p_in_range;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_sample <= 13'sd2047 && i_sample >= -13'sd2048) |=> pipe_q[0].word == 12'($past(i_sample) + 13'sd2048);
	endproperty
	a_in_range: assert property (p_in_range) else $error("in-range code not offset binary");
endmodule : padc_core

/* File: rtl/padc_defs.svh */
`ifndef PADC_DEFS_SVH
`define PADC_DEFS_SVH
`define PADC_WORD_W 12
`define PADC_LATENCY 6
`define PADC_CODE_MIN 12'h000
`define PADC_CODE_MAX 12'hFFF
`define PADC_SAMPLE_W 13
`define PADC_OE_DRIVE 12'h000
`define PADC_OE_FLOAT 12'hFFF
`endif

/* File: rtl/padc_pkg.sv */
`include "padc_defs.svh"
package padc_pkg;
	typedef struct packed {
		logic valid;
		logic [`PADC_WORD_W-1:0] word;
	} padc_beat_type;
	typedef enum logic [1:0] {
		PADC_ST_SLEEP = 2'b00,
		PADC_ST_FILL = 2'b01,
		PADC_ST_RUN = 2'b10
	} padc_state_type;
endpackage : padc_pkg

/* File: rtl/padc_skid.sv */
`timescale 1ns/1ps
`include "padc_defs.svh"
// two-entry buffer; accepts while at least one slot is free
module padc_skid #(
	parameter int WIDTH = `PADC_WORD_W
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	logic [WIDTH-1:0] mem_q [2];
	logic rd_q;
	logic wr_q;
	logic [1:0] cnt_q;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;
	assign o_ready = (cnt_q != 2'd2);
	assign o_valid = (cnt_q != 2'd0);
	assign o_data = mem_q[rd_q];
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'd0;
		end
		else
		begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (push)
			mem_q[wr_q] <= i_data;
	end
	property p_no_overflow;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		cnt_q <= 2'd2;
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("buffer count above two");
endmodule : padc_skid

/* File: sim/padc_capture.sv */
`timescale 1ns/1ps
// capture side: stalls on command, drops the refill words after each wake
module padc_capture (
	input wire logic i_sys_clk,
	input wire logic i_hold,
	input wire logic i_sleeping,
	input wire logic i_word_valid,
	output logic o_capture_ready,
	output int o_taken
);
	int skip = 6;
	initial o_capture_ready = 1'b0;
	initial o_taken = 0;
	always @(negedge i_sys_clk)
		o_capture_ready <= ~i_hold;
	always @(posedge i_sys_clk)
	begin
		if (i_sleeping)
			skip <= 6;
		else if (i_word_valid && o_capture_ready && skip > 0)
			skip <= skip - 1;
		else if (i_word_valid && o_capture_ready)
			o_taken <= o_taken + 1;
	end
endmodule : padc_capture

/* File: sim/test_pipelined_adc_output_port.sv */
`timescale 1ns/1ps
`include "padc_defs.svh"
module test_pipelined_adc_output_port;
	import padc_pkg::*;
	logic i_sys_clk = 0;
	logic i_rst_n = 0;
	logic i_out_en_n = 1;
	logic i_sleep_request = 0;
	logic hold = 1;
	logic oe_q = 1;
	logic signed [`PADC_SAMPLE_W-1:0] i_sample = '0;
	logic i_capture_ready, valid, sleeping, stall;
	logic [11:0] word, oe_n;
	logic [11:0] hist[int];
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;
	int taken;
	int pulses = 0;
	always #50 i_sys_clk = ~i_sys_clk; // 10 MHz, inside the converter's clock range
	padc_core i_dut (.i_sys_clk, .i_rst_n, .i_sample, .i_out_en_n, .i_sleep_request, .i_capture_ready,
		.o_conversion_word(word), .o_conversion_word_oe_n(oe_n), .o_word_valid(valid),
		.o_sleeping(sleeping), .o_stall(stall));
	padc_capture i_far (.i_sys_clk, .i_hold(hold), .i_sleeping(sleeping), .i_word_valid(valid),
		.o_capture_ready(i_capture_ready), .o_taken(taken));
	function automatic logic [11:0] code(int s);
		if (s > 2047)
			return 12'hFFF;
		if (s < -2048)
			return 12'h000;
		return 12'(s + 2048);
	endfunction : code
	task automatic check(logic [11:0] seen, logic [11:0] want);
		comparisons++;
		if (seen !== want)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic wait_n(int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : wait_n
	// steady conversion: a word every cycle, random codes including over and under range
	task automatic run(int n);
		repeat (n)
		begin
			check({11'h0, valid}, 12'h001);
			i_sample = 13'($urandom);
			i_out_en_n = 1'($urandom);
			wait_n(1);
		end
	endtask : run
	always @(posedge i_sys_clk)
	begin
		cyc++;
		hist[cyc] = code(i_sample);
		oe_q <= i_out_en_n;
		if (valid === 1'b1 && i_capture_ready === 1'b1 && sleeping === 1'b0)
			pulses++;
	end
	always @(negedge i_sys_clk)
		if (i_rst_n)
		begin
			if (valid === 1'b1)
				check(word, hist[cyc - `PADC_LATENCY]);
			check(oe_n, oe_q ? 12'hFFF : 12'h000);
		end
	initial
	begin
		#(2000 * 100);
		mismatches++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(11));
		wait_n(4);
		i_rst_n = 1;
		hold = 0;
		wait_n(10);
		run(200);
		i_sample = -13'sd5;
		wait_n(10);
		hold = 1;
		wait_n(12);
		check({11'h0, stall}, 12'h001);
		hold = 0;
		wait_n(12);
		check({11'h0, stall}, 12'h000);
		i_sleep_request = 1;
		wait_n(10);
		repeat (10)
		begin
			check({10'h0, sleeping, valid}, 12'h002);
			wait_n(1);
		end
		i_sleep_request = 0;
		wait_n(10);
		check({11'h0, sleeping}, 12'h000);
		run(100);
		check(12'(taken), 12'(pulses - 12));
		end_of_test();
	end
endmodule : test_pipelined_adc_output_port
